// ### core/mmu_sfr_access_mode_control.sv
// Address translation, partition/segment checks, register filter, mode control
`timescale 1ns/1ps
module mmu_sfr_access_mode_control (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Strap levels sampled after reset, plus the boot completion input, which is used live
  input wire logic test_enable_i,
  input wire logic cless_variant_i,
  input wire logic part_upper_i,
  input wire logic boot_done_i,
  // CPU memory access
  input wire logic cpu_req_i,
  input wire mmu_pkg::acc_kind_t cpu_kind_i,
  input wire logic [23:0] cpu_vaddr_i,
  output logic mem_req_o,
  output logic [23:0] mem_paddr_o,
  output logic mem_fault_o,
  // CPU mode events
  input wire logic call_i,
  input wire logic [23:0] call_target_i,
  input wire logic exception_i,
  input wire logic interrupt_i,
  input wire logic irq_return_i,
  input wire logic irq_active_i,
  output logic [1:0] mode_bits_o,
  output logic skip_push_o,
  output logic mode_fault_o,
  // CPU peripheral register access
  input wire logic sfr_req_i,
  input wire logic sfr_we_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_tgt_rdata_i,
  output logic sfr_tgt_req_o,
  output logic [1:0] sfr_bank_o,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_refused_o,
  output logic [15:0] grp_rights_o,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import mmu_pkg::*;
  // Mode state
  logic [1:0] mbits_q, mbits_d, saved_q, saved_d;
  logic boot_q, test_q, cless_q, upper_q, test_lat_q, straps_q;
  logic irq_user_q;
  cpu_mode_t mode;
  // Segment table
  logic [23:0] seg_start_q [NUM_SEG];
  logic [23:0] seg_end_q [NUM_SEG];
  logic [23:0] seg_offs_q [NUM_SEG];
  logic [2:0] seg_rt_q [NUM_SEG];
  logic [15:0] seg_grp_q [NUM_SEG];
  logic [5:0] seg_sel_q;
  logic [6:0] seg_cnt_q;
  logic [15:0] cless_grp_q;
  logic [2:0] fault_q;
  assign mode = mbits_q[BIT_SUPER] ? (boot_q ? M_BOOT : (test_q ? M_TEST : M_CLESS)) :
                mbits_q[BIT_PRIV] ? M_SYSTEM : M_USER;
  wire is_user = (mode == M_USER);
  wire is_sys = (mode == M_SYSTEM);
  // Straps captured once after reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      straps_q <= 1'b0;
      upper_q <= 1'b0;
      test_lat_q <= 1'b0;
      cless_q <= 1'b0;
    end else if (!straps_q) begin
      straps_q <= 1'b1;
      upper_q <= part_upper_i;
      test_lat_q <= test_enable_i;
      cless_q <= cless_variant_i;
    end
  end
  // Segment hit search, first matching entry wins
  logic [NUM_SEG-1:0] hit_vec;
  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : g_seg
      assign hit_vec[g] = (7'(g) < seg_cnt_q) && (cpu_vaddr_i >= seg_start_q[g]) &&
                          (cpu_vaddr_i <= seg_end_q[g]);
    end
  endgenerate
  logic seg_hit;
  logic [5:0] seg_idx;
  always_comb begin
    seg_hit = 1'b0;
    seg_idx = 6'h00;
    for (int i = NUM_SEG - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        seg_hit = 1'b1;
        seg_idx = 6'(i);
      end
    end
  end
  wire [23:0] paddr = is_user ? (cpu_vaddr_i + seg_offs_q[seg_idx]) : cpu_vaddr_i;
  wire [2:0] rt = seg_rt_q[seg_idx];
  wire kind_ok = (cpu_kind_i == AC_READ) ? rt[RT_READ] :
                 (cpu_kind_i == AC_WRITE) ? rt[RT_WRITE] : rt[RT_EXEC];
  wire seg_ok = !is_user || (seg_hit && kind_ok);
  // Partition half of each region, half selected by strap, both halves in test mode
  function automatic logic in_part(input logic [23:0] a, b, s, input logic both, up);
    logic [23:0] half;
    half = s >> 1;
    if (a < b || a >= b + s) return 1'b0;
    if (both) return 1'b1;
    return up ? (a >= b + half) : (a < b + half);
  endfunction
  wire both = (mode == M_TEST);
  wire implemented = (paddr >= ROM_BASE && paddr < ROM_BASE + ROM_SIZE) ||
                     (paddr >= RAM_BASE && paddr < RAM_BASE + RAM_SIZE) ||
                     (paddr >= EE_BASE && paddr < EE_BASE + EE_SIZE);
  wire part_ok = in_part(paddr, ROM_BASE, ROM_SIZE, both, upper_q) ||
                 in_part(paddr, RAM_BASE, RAM_SIZE, both, upper_q) ||
                 in_part(paddr, EE_BASE, EE_SIZE, both, upper_q);
  wire acc_ok = implemented && part_ok && seg_ok;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mem_req_o <= 1'b0;
      mem_paddr_o <= 24'h000000;
      mem_fault_o <= 1'b0;
    end else begin
      mem_req_o <= cpu_req_i && acc_ok;
      mem_paddr_o <= (cpu_req_i && acc_ok) ? paddr : mem_paddr_o;
      mem_fault_o <= cpu_req_i && !acc_ok;
    end
  end
  // Group rights per mode
  wire [15:0] grp = is_user ? (seg_hit ? seg_grp_q[seg_idx] : 16'h0000) :
                    (mode == M_CLESS) ? cless_grp_q : 16'hFFFF;
  assign grp_rights_o = grp;
  // Register filter: 0x00-0x3F groups, 0x40-0x7E fixed table, 0x7F mode, 0x80+ banked
  wire [3:0] sfr_grp = sfr_addr_i[5:2];
  wire sfr_in_grp = (sfr_addr_i[7:6] == 2'h0);
  wire sfr_banked = sfr_addr_i[7];
  // Fixed table: bit0 read-only function, bit1 write-only function, bit2 privileged
  wire fx_ro = sfr_addr_i[0];
  wire fx_wo = sfr_addr_i[1];
  wire fx_priv = sfr_addr_i[2];
  wire fix_ok = !(sfr_we_i && fx_ro) && !(!sfr_we_i && fx_wo) &&
                !(fx_priv && (is_user || mode == M_CLESS));
  wire mode_reg = (sfr_addr_i == 8'h7F);
  wire sfr_ok = sfr_banked || mode_reg || (sfr_in_grp ? grp[sfr_grp] : fix_ok);
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sfr_tgt_req_o <= 1'b0;
      sfr_bank_o <= 2'h0;
      sfr_refused_o <= 1'b0;
    end else begin
      sfr_tgt_req_o <= sfr_req_i && sfr_ok;
      sfr_bank_o <= is_user ? 2'h0 : (is_sys ? 2'h1 : 2'h2);
      sfr_refused_o <= sfr_req_i && !sfr_ok;
    end
  end
  assign sfr_rdata_o = sfr_refused_o ? REFUSED_READ_VAL[7:0] : sfr_tgt_rdata_i;
  // Mode transitions
  wire mode_wr = sfr_req_i && sfr_we_i && mode_reg;
  wire sys_call = call_i && ((call_target_i & VEC_MASK) == SYS_VEC_BASE);
  wire cfg_call = call_i && ((call_target_i & VEC_MASK) == CFG_VEC_BASE);
  wire uentry = call_i && is_sys && (call_target_i == USER_ENTRY_ADDR);
  wire ret_bad = irq_return_i && is_user && !(irq_user_q && irq_active_i);
  wire sys_call_bad = sys_call && !is_user;
  logic mfault_d;
  always_comb begin
    mbits_d = mbits_q;
    saved_d = saved_q;
    mfault_d = 1'b0;
    if (exception_i || sys_call_bad || ret_bad) begin
      saved_d = mbits_q;
      mbits_d = 2'b01;
      mfault_d = sys_call_bad || ret_bad;
    end else if (interrupt_i) begin
      saved_d = mbits_q;
      mbits_d = irq_user_q ? 2'b00 : 2'b01;
    end else if (sys_call) begin
      saved_d = mbits_q;
      mbits_d = 2'b01;
    end else if (cfg_call && !cless_q) begin
      saved_d = mbits_q;
      mbits_d = 2'b10;
    end else if (uentry) begin
      mbits_d = 2'b00;
    end else if (irq_return_i) begin
      mbits_d = saved_q;
    end else if (mode_wr) begin
      mbits_d = mbits_q & sfr_wdata_i[1:0];
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mbits_q <= 2'b10;
      saved_q <= 2'b00;
      boot_q <= 1'b1;
      test_q <= 1'b0;
      mode_fault_o <= 1'b0;
      skip_push_o <= 1'b0;
    end else begin
      mbits_q <= mbits_d;
      saved_q <= saved_d;
      mode_fault_o <= mfault_d;
      skip_push_o <= uentry && !exception_i && !interrupt_i;
      if (boot_q && boot_done_i && straps_q) begin
        boot_q <= 1'b0;
        test_q <= test_lat_q;
      end else if (!boot_q && !mbits_q[BIT_SUPER]) begin
        test_q <= 1'b0;
      end
    end
  end
  assign mode_bits_o = mbits_q;
  // AXI4-Lite slave
  logic aw_q, w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_wr = aw_q && w_q && !s_axi_bvalid;
  wire seg_wr_ok = is_sys;
  wire cl_wr_ok = mode != M_CLESS && !is_user;
  wire wr_known = awaddr_q == OFF_CTRL || awaddr_q == OFF_SEG_SEL ||
                  awaddr_q == OFF_SEG_START || awaddr_q == OFF_SEG_END ||
                  awaddr_q == OFF_SEG_OFFS || awaddr_q == OFF_SEG_RIGHTS ||
                  awaddr_q == OFF_CL_GRP_LO || awaddr_q == OFF_CL_GRP_HI ||
                  awaddr_q == OFF_SEG_COUNT;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      seg_sel_q <= 6'h00;
      seg_cnt_q <= 7'h00;
      cless_grp_q <= 16'h0000;
      irq_user_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_wr) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_q == OFF_CTRL && is_sys) irq_user_q <= wdata_q[0];
        if (awaddr_q == OFF_SEG_SEL && seg_wr_ok) seg_sel_q <= wdata_q[5:0];
        if (awaddr_q == OFF_SEG_COUNT && seg_wr_ok) begin
          seg_cnt_q <= (wdata_q[6:0] > 7'h40) ? 7'h40 : wdata_q[6:0];
        end
        if (awaddr_q == OFF_CL_GRP_LO && cl_wr_ok) cless_grp_q[7:0] <= wdata_q[7:0];
        if (awaddr_q == OFF_CL_GRP_HI && cl_wr_ok) cless_grp_q[15:8] <= wdata_q[7:0];
      end
    end
  end
  // Segment entry storage, five fields per entry
  always_ff @(posedge clk_sys_i) begin
    if (do_wr && seg_wr_ok) begin
      if (awaddr_q == OFF_SEG_START) seg_start_q[seg_sel_q] <= wdata_q[23:0];
      if (awaddr_q == OFF_SEG_END) seg_end_q[seg_sel_q] <= wdata_q[23:0];
      if (awaddr_q == OFF_SEG_OFFS) seg_offs_q[seg_sel_q] <= wdata_q[23:0];
      if (awaddr_q == OFF_SEG_RIGHTS) begin
        seg_rt_q[seg_sel_q] <= wdata_q[2:0];
        seg_grp_q[seg_sel_q] <= wdata_q[31:16];
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) fault_q <= 3'h0;
    else fault_q <= fault_q | {mode_fault_o, mem_fault_o, sfr_refused_o};
  end
  logic [31:0] rd;
  logic rd_ok;
  always_comb begin
    rd = UNMAPPED_VAL;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL: rd = {31'h0, irq_user_q};
      OFF_STATUS: rd = {24'h0, 2'h0, upper_q, test_q, boot_q, mode == M_CLESS, mbits_q};
      OFF_SEG_SEL: rd = {26'h0, seg_sel_q};
      OFF_SEG_START: rd = {8'h0, seg_start_q[seg_sel_q]};
      OFF_SEG_END: rd = {8'h0, seg_end_q[seg_sel_q]};
      OFF_SEG_OFFS: rd = {8'h0, seg_offs_q[seg_sel_q]};
      OFF_SEG_RIGHTS: rd = {seg_grp_q[seg_sel_q], 13'h0, seg_rt_q[seg_sel_q]};
      OFF_CL_GRP_LO: rd = {24'h0, cless_grp_q[7:0]};
      OFF_CL_GRP_HI: rd = {24'h0, cless_grp_q[15:8]};
      OFF_SEG_COUNT: rd = {25'h0, seg_cnt_q};
      OFF_FAULT: rd = {29'h0, fault_q};
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // Checks
  property p_boot_after_reset;
    @(posedge clk_sys_i) $fell(srst_i) |-> mbits_q == 2'b10 && boot_q;
  endproperty
  a_boot_after_reset: assert property (p_boot_after_reset) else $error("not boot");
  property p_no_set;
    @(posedge clk_sys_i) disable iff (srst_i)
      mode_wr && !call_i && !exception_i && !interrupt_i && !irq_return_i
      |=> (mbits_q & ~$past(mbits_q)) == 2'b00;
  endproperty
  a_no_set: assert property (p_no_set) else $error("mode bit set by write");
  property p_fault_no_fwd;
    @(posedge clk_sys_i) disable iff (srst_i) mem_fault_o |-> !mem_req_o;
  endproperty
  a_fault_no_fwd: assert property (p_fault_no_fwd) else $error("fault forwarded");
  property p_full_grp;
    @(posedge clk_sys_i) disable iff (srst_i) (is_sys || mode == M_BOOT) |-> grp_rights_o == 16'hFFFF;
  endproperty
  a_full_grp: assert property (p_full_grp) else $error("group rights not full");
  property p_sys_call_bad;
    @(posedge clk_sys_i) disable iff (srst_i)
      sys_call && !is_user && !exception_i |=> mode_fault_o && mbits_q == 2'b01;
  endproperty
  a_sys_call_bad: assert property (p_sys_call_bad) else $error("system call fault missing");
  property p_refused_read;
    @(posedge clk_sys_i) disable iff (srst_i) sfr_refused_o |-> sfr_rdata_o == 8'h00 && !sfr_tgt_req_o;
  endproperty
  a_refused_read: assert property (p_refused_read) else $error("refused read leaks");
  property p_user_entry;
    @(posedge clk_sys_i) disable iff (srst_i)
      uentry && !exception_i && !interrupt_i |=> mbits_q == 2'b00 && skip_push_o;
  endproperty
  a_user_entry: assert property (p_user_entry) else $error("user entry failed");
  property p_irq_return;
    @(posedge clk_sys_i) disable iff (srst_i)
      irq_return_i && !ret_bad && !exception_i && !interrupt_i && !call_i
      |=> mbits_q == $past(saved_q);
  endproperty
  a_irq_return: assert property (p_irq_return) else $error("return did not restore");
  c_user_mode: cover property (@(posedge clk_sys_i) disable iff (srst_i) is_user && mem_req_o);
  c_mem_fault: cover property (@(posedge clk_sys_i) disable iff (srst_i) mem_fault_o);
  c_sfr_refuse: cover property (@(posedge clk_sys_i) disable iff (srst_i) sfr_refused_o);
endmodule

// ### core/mmu_pkg.sv
// Constants and types for the protection and mode control block
package mmu_pkg;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned NUM_SEG = 64;
  localparam int unsigned SEG_W = 6;
  localparam int unsigned NUM_GRP = 16;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_SEG_SEL = 12'h008;
  localparam logic [11:0] OFF_SEG_START = 12'h00C;
  localparam logic [11:0] OFF_SEG_END = 12'h010;
  localparam logic [11:0] OFF_SEG_OFFS = 12'h014;
  localparam logic [11:0] OFF_SEG_RIGHTS = 12'h018;
  localparam logic [11:0] OFF_CL_GRP_LO = 12'h01C;
  localparam logic [11:0] OFF_CL_GRP_HI = 12'h020;
  localparam logic [11:0] OFF_SEG_COUNT = 12'h024;
  localparam logic [11:0] OFF_FAULT = 12'h028;
  // Mode status bit positions
  localparam int unsigned BIT_PRIV = 0;
  localparam int unsigned BIT_SUPER = 1;
  // Segment rights field positions
  localparam int unsigned RT_READ = 0;
  localparam int unsigned RT_WRITE = 1;
  localparam int unsigned RT_EXEC = 2;
  // Special vectors
  localparam logic [23:0] USER_ENTRY_ADDR = 24'h800000;
  localparam logic [23:0] SYS_VEC_BASE = 24'h000100;
  localparam logic [23:0] CFG_VEC_BASE = 24'h000200;
  localparam logic [23:0] VEC_MASK = 24'hFFFF00;
  // Physical memory map, fixed partitions
  localparam logic [23:0] ROM_BASE = 24'h000000;
  localparam logic [23:0] ROM_SIZE = 24'h040000;
  localparam logic [23:0] RAM_BASE = 24'h100000;
  localparam logic [23:0] RAM_SIZE = 24'h004000;
  localparam logic [23:0] EE_BASE = 24'h200000;
  localparam logic [23:0] EE_SIZE = 24'h020000;
  localparam logic [31:0] REFUSED_READ_VAL = 32'h00000000;
  localparam logic [31:0] UNMAPPED_VAL = 32'hDEADBEEF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    M_BOOT, M_TEST, M_CLESS, M_SYSTEM, M_USER
  } cpu_mode_t;
  typedef enum logic [1:0] {
    AC_READ, AC_WRITE, AC_FETCH
  } acc_kind_t;
endpackage

// ### testbench/sfr_target_model.sv
// Peripheral register target with one storage copy per bank
`timescale 1ns/1ps
module sfr_target_model (
  input wire logic clk_sys_i,
  input wire logic sfr_req_i,
  input wire logic sfr_we_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_tgt_req_i,
  input wire logic [1:0] sfr_bank_i,
  output logic [7:0] sfr_tgt_rdata_o
);
  logic [7:0] mem_q [4][256];
  logic [7:0] addr_q, wdata_q, last_q;
  logic we_q;
  initial begin
    last_q = 8'h00;
    for (int b = 0; b < 4; b++) begin
      for (int a = 0; a < 256; a++) begin
        mem_q[b][a] = {b[3:0], b[3:0]};
      end
    end
  end
  // Latch the request as the block takes it
  always @(posedge clk_sys_i) begin
    if (sfr_req_i) begin
      addr_q <= sfr_addr_i;
      we_q <= sfr_we_i;
      wdata_q <= sfr_wdata_i;
    end
    if (sfr_tgt_req_i & we_q) begin
      mem_q[sfr_bank_i][addr_q] <= wdata_q;
    end
    if (sfr_tgt_req_i) begin
      last_q <= sfr_tgt_rdata_o;
    end
  end
  // Released data shows the inverse of the last value
  assign sfr_tgt_rdata_o = sfr_tgt_req_i ? mem_q[sfr_bank_i][addr_q] : ~last_q;
endmodule

// ### testbench/mmu_sfr_access_mode_control_tb.sv
// Self-checking bench for the protection and mode control block
`timescale 1ns/1ps
module mmu_sfr_access_mode_control_tb;
  import mmu_pkg::*;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, test_enable_i = 1'b0, cless_variant_i = 1'b0;
  logic part_upper_i = 1'b0, boot_done_i = 1'b0, cpu_req_i = 1'b0, call_i = 1'b0;
  logic exception_i = 1'b0, interrupt_i = 1'b0, irq_return_i = 1'b0, irq_active_i = 1'b0;
  logic sfr_req_i = 1'b0, sfr_we_i = 1'b0;
  acc_kind_t cpu_kind_i = AC_READ;
  logic [23:0] cpu_vaddr_i = 24'h000000, call_target_i = 24'h000000, mem_paddr_o;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_tgt_rdata_i, sfr_rdata_o;
  logic mem_req_o, mem_fault_o, skip_push_o, mode_fault_o, sfr_tgt_req_o, sfr_refused_o;
  logic [1:0] mode_bits_o, sfr_bank_o, s_axi_bresp, s_axi_rresp;
  logic [15:0] grp_rights_o;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic clr = 1'b0, s_req, s_flt, s_tgt, s_ref, s_skip, s_mflt;
  logic [23:0] pa;
  logic [7:0] rd;
  acc_kind_t nk = AC_READ;
  logic [23:0] na = 24'h000000;
  logic nw = 1'b0;
  logic [7:0] nd = 8'h00;
  int failures = 0;
  int n_tests = 0;

  mmu_sfr_access_mode_control mmu_sfr_access_mode_control_i (.clk_sys_i, .srst_i,
    .test_enable_i, .cless_variant_i, .part_upper_i, .boot_done_i, .cpu_req_i, .cpu_kind_i,
    .cpu_vaddr_i, .mem_req_o, .mem_paddr_o, .mem_fault_o, .call_i, .call_target_i,
    .exception_i, .interrupt_i, .irq_return_i, .irq_active_i, .mode_bits_o, .skip_push_o,
    .mode_fault_o, .sfr_req_i, .sfr_we_i, .sfr_addr_i, .sfr_wdata_i, .sfr_tgt_rdata_i,
    .sfr_tgt_req_o, .sfr_bank_o, .sfr_rdata_o, .sfr_refused_o, .grp_rights_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  sfr_target_model sfr_target_model_i (.clk_sys_i, .sfr_req_i, .sfr_we_i, .sfr_addr_i,
    .sfr_wdata_i, .sfr_tgt_req_i(sfr_tgt_req_o), .sfr_bank_i(sfr_bank_o),
    .sfr_tgt_rdata_o(sfr_tgt_rdata_i));

  always #2 clk_sys_i = ~clk_sys_i;

  // Sticky capture of answer pulses
  always @(posedge clk_sys_i) begin
    s_req <= ~clr & (s_req | mem_req_o);
    s_flt <= ~clr & (s_flt | mem_fault_o);
    s_tgt <= ~clr & (s_tgt | sfr_tgt_req_o);
    s_ref <= ~clr & (s_ref | sfr_refused_o);
    s_skip <= ~clr & (s_skip | skip_push_o);
    s_mflt <= ~clr & (s_mflt | mode_fault_o);
    if (mem_req_o) pa <= mem_paddr_o;
    if (sfr_tgt_req_o | sfr_refused_o) rd <= sfr_rdata_o;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic rst(input logic t, input logic u, input logic v);
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    test_enable_i <= t;
    part_upper_i <= u;
    cless_variant_i <= v;
    boot_done_i <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask

  // k: 0 memory, 1 register, 2 call, 3 exception, 4 interrupt, 5 return
  task automatic go(input int k);
    @(posedge clk_sys_i);
    clr <= 1'b1;
    cpu_kind_i <= nk;
    cpu_vaddr_i <= na;
    call_target_i <= na;
    sfr_addr_i <= na[7:0];
    sfr_we_i <= nw;
    sfr_wdata_i <= nd;
    {irq_return_i, interrupt_i, exception_i, call_i, sfr_req_i, cpu_req_i} <= 6'(1 << k);
    @(posedge clk_sys_i);
    clr <= 1'b0;
    {irq_return_i, interrupt_i, exception_i, call_i, sfr_req_i, cpu_req_i} <= 6'h00;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic mem(input acc_kind_t k, input logic [23:0] a, input logic ok,
                     input logic [23:0] e);
    nk = k;
    na = a;
    go(0);
    chk(s_req, ok);
    chk(s_flt, !ok);
    if (ok) chk(pa, e);
  endtask

  task automatic sfr(input logic we, input logic [7:0] a, input logic [7:0] d,
                     input logic ok, input logic [7:0] e);
    nw = we;
    na = {16'h0000, a};
    nd = d;
    go(1);
    chk(s_tgt, ok);
    chk(s_ref, !ok);
    if (!we) chk(rd, ok ? e : REFUSED_READ_VAL[7:0]);
  endtask

  task automatic mb(input logic [7:0] d, input logic [1:0] e);
    nw = 1'b1;
    na = 24'h00007F;
    nd = d;
    go(1);
    chk(mode_bits_o, e);
  endtask

  task automatic ev(input int k, input logic [23:0] t, input logic [1:0] e);
    na = t;
    go(k);
    chk(mode_bits_o, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(n < 50, 1'b1);
    chk(s_axi_bresp, r);
  endtask

  task automatic rdr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(n < 50, 1'b1);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask

  initial begin
    #100000;
    failures++;
    wrap_up();
  end

  initial begin
    rst(1'b0, 1'b0, 1'b0);
    chk(mode_bits_o, 2'b10);
    chk(grp_rights_o, 16'hFFFF);
    mem(AC_READ, 24'h001000, 1'b1, 24'h001000);
    mem(AC_READ, 24'h030000, 1'b0, 24'h0);
    mem(AC_READ, 24'h102000, 1'b0, 24'h0);
    mem(AC_READ, 24'h050000, 1'b0, 24'h0);
    wr(OFF_CL_GRP_LO, 32'h0, RESP_OKAY);
    wr(OFF_CL_GRP_HI, 32'h0, RESP_OKAY);
    rdr(12'hFFC, UNMAPPED_VAL, RESP_SLVERR);
    wr(12'hFFC, 32'h1, RESP_SLVERR);
    @(posedge clk_sys_i);
    boot_done_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk(mode_bits_o, 2'b10);
    chk(grp_rights_o, 16'h0000);
    wr(OFF_CL_GRP_LO, 32'hFFFFFFFF, RESP_OKAY);
    rdr(OFF_CL_GRP_LO, 32'h0, RESP_OKAY);
    chk(grp_rights_o, 16'h0000);
    sfr(1'b0, 8'h04, 8'h00, 1'b0, 8'h00);
    sfr(1'b1, 8'h04, 8'h33, 1'b0, 8'h00);
    sfr(1'b1, 8'h80, 8'h5A, 1'b1, 8'h00);
    sfr(1'b0, 8'h80, 8'h00, 1'b1, 8'h5A);
    mb(8'h03, 2'b10);
    mb(8'h00, 2'b00);
    mb(8'hFF, 2'b00);
    sfr(1'b0, 8'h80, 8'h00, 1'b1, 8'h00);
    sfr(1'b0, 8'h44, 8'h00, 1'b0, 8'h00);
    sfr(1'b1, 8'h41, 8'h77, 1'b0, 8'h00);
    sfr(1'b1, 8'h42, 8'h77, 1'b1, 8'h00);
    ev(2, SYS_VEC_BASE, 2'b01);
    chk(s_mflt, 1'b0);
    ev(5, 24'h0, 2'b00);
    ev(3, 24'h0, 2'b01);
    ev(4, 24'h0, 2'b01);
    ev(5, 24'h0, 2'b01);
    ev(2, SYS_VEC_BASE, 2'b01);
    chk(s_mflt, 1'b1);
    chk(grp_rights_o, 16'hFFFF);
    sfr(1'b0, 8'h80, 8'h00, 1'b1, 8'h11);
    wr(OFF_SEG_SEL, 32'h0, RESP_OKAY);
    wr(OFF_SEG_START, 32'h001000, RESP_OKAY);
    wr(OFF_SEG_END, 32'h001FFF, RESP_OKAY);
    wr(OFF_SEG_OFFS, 32'h000100, RESP_OKAY);
    wr(OFF_SEG_RIGHTS, 32'h00020001, RESP_OKAY);
    wr(OFF_SEG_COUNT, 32'h1, RESP_OKAY);
    rdr(OFF_SEG_START, 32'h001000, RESP_OKAY);
    wr(OFF_CTRL, 32'h1, RESP_OKAY);
    rdr(OFF_CTRL, 32'h1, RESP_OKAY);
    mem(AC_FETCH, 24'h001800, 1'b1, 24'h001800);
    ev(2, USER_ENTRY_ADDR, 2'b00);
    chk(s_skip, 1'b1);
    mem(AC_READ, 24'h001010, 1'b1, 24'h001110);
    chk(grp_rights_o, 16'h0002);
    mem(AC_WRITE, 24'h001010, 1'b0, 24'h0);
    mem(AC_FETCH, 24'h001010, 1'b0, 24'h0);
    mem(AC_READ, 24'h002000, 1'b0, 24'h0);
    ev(5, 24'h0, 2'b01);
    chk(s_mflt, 1'b1);
    mb(8'h00, 2'b00);
    ev(4, 24'h0, 2'b00);
    @(posedge clk_sys_i);
    irq_active_i <= 1'b1;
    ev(5, 24'h0, 2'b00);
    chk(s_mflt, 1'b0);
    ev(2, CFG_VEC_BASE, 2'b10);
    rdr(OFF_STATUS, 32'h6, RESP_OKAY);
    rdr(OFF_FAULT, 32'h7, RESP_OKAY);
    rst(1'b1, 1'b1, 1'b1);
    chk(mode_bits_o, 2'b10);
    mem(AC_READ, 24'h001000, 1'b0, 24'h0);
    mem(AC_READ, 24'h030000, 1'b1, 24'h030000);
    @(posedge clk_sys_i);
    boot_done_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    mem(AC_READ, 24'h001000, 1'b1, 24'h001000);
    mb(8'h00, 2'b00);
    ev(2, CFG_VEC_BASE, 2'b00);
    wrap_up();
  end
endmodule
